// [common/copc_params.svh]
// Behaviour
// - aux gain code sets gain in 3 dB steps, 15=+24, 7=0, 0=-21.
// - stereo beep power bit, mixing to headphone and speaker bits.
// - mono beep power bit, mixing to headphone and speaker bits.
// - headphone power bits clear: common falls, outputs low; set: common up.
// - both shutdown bits set: headphone amp down, outputs low.
// - speaker power clear: speaker blocks down, pins high impedance.
// - save-off clear: power save, positive pin hi-z, negative half supply.
// - mono out enable clear: mono out 2 off, pin at reference.
// - dac and mic bits route signals to mono line output.
// - mono line power clear: line output down and high impedance.
// - mono gain select chooses 6 dB or -17 dB.
// - at or above limit, attenuate 0.5 dB every two sample periods.
// - recovery raises 1 dB at zero crossing, timeout 2048 samples.
// - recovery period 2048 samples, or 512 when period select set.
// - between target and limit, gain is held.
// - speaker power rise starts 2048/512 sample init, control disabled.
// - frame is chip address, read/write, 5-bit address, 8 data bits.
// - chip address high bit 1, low bit strap; mismatch ignored.
// - sample on serial clock rise, shift read data on fall.
// - select rise commits write data and releases data out.
// - power-down pin low holds registers at reset values.
`ifndef COPC_PARAMS_SVH
`define COPC_PARAMS_SVH
// ****
// serial frame
// ****
`define COPC_FRAME_BITS 5'h10
`define COPC_HDR_BITS   5'h08
`define COPC_CHIP_HI    1'b1
`define COPC_RW_READ    1'b1
`define COPC_NUM_REGS   5'h0F
// ****
// register addresses
// ****
`define COPC_A_PM1  4'h0
`define COPC_A_PM2  4'h1
`define COPC_A_SEL1 4'h2
`define COPC_A_SEL2 4'h3
`define COPC_A_MOD2 4'h5
`define COPC_A_TMR  4'h8
`define COPC_A_ALC  4'h9
`define COPC_A_VOL  4'hE
// ****
// field positions
// ****
`define COPC_B_BPS   6
`define COPC_B_BPM   5
`define COPC_B_MONO_LINE_POWER  3
`define COPC_B_SPK_POWER 3
`define COPC_B_HP_LEFT_POWER 2
`define COPC_B_HP_RIGHT_POWER 1
`define COPC_B_MONO_GAIN_SEL  7
`define COPC_B_DAC_TO_MONO  5
`define COPC_B_MIC_TO_MONO  4
`define COPC_B_STEREO_BEEP_TO_SPK 3
`define COPC_B_MONO_BEEP_TO_SPK 2
`define COPC_B_MOUT  0
`define COPC_B_STEREO_BEEP_TO_HP 3
`define COPC_B_MONO_BEEP_TO_HP 2
`define COPC_B_HPLSD 1
`define COPC_B_HPRSD 0
`define COPC_B_SPEAKER_SAVE_OFF  0
`define COPC_B_RECOVERY_PERIOD_SEL  6
`define COPC_B_SPEAKER_LEVEL_CTL_EN  6
// ****
// reset values
// ****
`define COPC_RST_ZERO 8'h00
`define COPC_RST_ALC  8'h40
`define COPC_RST_VOL  8'h07
`define COPC_RST_FSDIV 16'h11B7
// ****
// aux gain mapping
// ****
`define COPC_AUX_STEP_DB 6'h03
`define COPC_AUX_MIN_DB  6'h15
// ****
// level control timing in sample periods; attenuation steps and ceiling
// ****
`define COPC_LIM_FS     1'b1
`define COPC_REC_LONG   13'h0800
`define COPC_REC_SHORT  13'h0200
`define COPC_ZC_TIMEOUT 13'h0800
`define COPC_ATT_LIM    8'h01
`define COPC_ATT_REC    8'h02
`define COPC_ATT_MAX    8'hFF
// ****
// apb map
// ****
`define COPC_APB_FSDIV  8'h00
`define COPC_APB_STATUS 8'h04
`endif

// [common/copc_pkg.sv]
package copc_pkg;
  // level controller phases
  typedef enum logic [1:0] {
    LVL_OFF,
    LVL_INIT,
    LVL_RUN
  } copc_lvl_t;
endpackage : copc_pkg

// [hw/copc_spk_level.sv]
`timescale 1ns/1ps
`include "copc_params.svh"
module copc_spk_level (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // timing and control
  input  wire logic       fs_tick_i,
  input  wire logic       spk_power_i,
  input  wire logic       level_en_i,
  input  wire logic       period_sel_i,
  // level detectors
  input  wire logic       above_limit_i,
  input  wire logic       below_target_i,
  input  wire logic       zero_cross_i,
  // results
  output logic [7:0]      atten_o,
  output logic            init_busy_o,
  output logic            limiting_o
);
  copc_pkg::copc_lvl_t state_reg, state_next;
  logic [12:0] cnt_reg, cnt_next;
  logic [7:0]  att_reg, att_next;
  logic        ph_reg;
  logic        pwr_prev_reg;

  wire        pwr_rise = spk_power_i & ~pwr_prev_reg;
  wire [12:0] period = period_sel_i ? `COPC_REC_SHORT : `COPC_REC_LONG;
  wire        run_on = (state_reg == copc_pkg::LVL_RUN) & level_en_i;
  wire        lim_on = run_on & above_limit_i;
  wire        rec_on = run_on & ~above_limit_i & below_target_i;
  wire        lim_step = lim_on & fs_tick_i & (ph_reg == `COPC_LIM_FS);
  wire        rec_due = cnt_reg >= period;
  // a missing zero crossing must not stall recovery forever
  wire        rec_step = rec_on & rec_due & (zero_cross_i |
                (cnt_reg >= period + `COPC_ZC_TIMEOUT));
  wire [12:0] cnt_inc = (cnt_reg == 13'h1FFF) ? cnt_reg : cnt_reg + 13'h0001;

  // phase and step selection
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    att_next = att_reg;
    case (state_reg)
      copc_pkg::LVL_OFF: begin
        cnt_next = 13'h0000;
        att_next = 8'h00;
      end
      copc_pkg::LVL_INIT: begin
        if (fs_tick_i) begin
          cnt_next = cnt_inc;
        end
        if (fs_tick_i && cnt_inc >= period) begin
          state_next = copc_pkg::LVL_RUN;
          cnt_next = 13'h0000;
        end
      end
      copc_pkg::LVL_RUN: begin
        if (lim_step) begin
          att_next = (att_reg == `COPC_ATT_MAX) ? att_reg : att_reg + `COPC_ATT_LIM;
        end
        if (!rec_on) begin
          cnt_next = 13'h0000;
        end else if (rec_step) begin
          cnt_next = 13'h0000;
          att_next = (att_reg < `COPC_ATT_REC) ? 8'h00 : att_reg - `COPC_ATT_REC;
        end else if (fs_tick_i) begin
          cnt_next = cnt_inc;
        end
      end
      default: state_next = copc_pkg::LVL_OFF;
    endcase
    if (!spk_power_i) begin
      state_next = copc_pkg::LVL_OFF;
    end else if (pwr_rise) begin
      state_next = copc_pkg::LVL_INIT;
      cnt_next = 13'h0000;
    end
  end

  // state registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= copc_pkg::LVL_OFF;
      cnt_reg <= 13'h0000;
      att_reg <= 8'h00;
      ph_reg <= 1'b0;
      pwr_prev_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      att_reg <= att_next;
      ph_reg <= lim_on ? (ph_reg ^ fs_tick_i) : 1'b0;
      pwr_prev_reg <= spk_power_i;
    end
  end

  assign atten_o = att_reg;
  assign init_busy_o = (state_reg == copc_pkg::LVL_INIT);
  assign limiting_o = lim_on;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence rise_s;
    pwr_rise && spk_power_i;
  endsequence
  lim_step_a: assert property (lim_step && att_reg != `COPC_ATT_MAX |=>
    att_reg == $past(att_reg) + `COPC_ATT_LIM) else $error("limit step wrong");
  rec_step_a: assert property (rec_step && !lim_step && att_reg >= `COPC_ATT_REC |=>
    att_reg == $past(att_reg) - `COPC_ATT_REC) else $error("recovery step wrong");
  rec_wait_a: assert property (rec_step |-> cnt_reg >= period)
    else $error("recovery before period");
  hold_a: assert property (run_on && !above_limit_i && !below_target_i |=>
    $stable(att_reg)) else $error("gain moved in window");
  init_start_a: assert property (rise_s |=> state_reg == copc_pkg::LVL_INIT [*2])
    else $error("init not started");
  init_freeze_a: assert property (state_reg == copc_pkg::LVL_INIT |=> $stable(att_reg))
    else $error("gain moved during init");
  pwr_off_a: assert property (!spk_power_i |=> state_reg == copc_pkg::LVL_OFF)
    else $error("active while powered down");
endmodule : copc_spk_level

// [hw/copc_top.sv]
// The register offsets and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
`include "copc_params.svh"
module copc_top (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // apb slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // serial control pins
  input  wire logic        chip_select_n_i,
  input  wire logic        ctrl_serial_clock_i,
  input  wire logic        ctrl_data_in_i,
  output logic             ctrl_data_out_o,
  output logic             ctrl_data_out_oe_o,
  input  wire logic        addr_strap_pin_i,
  input  wire logic        power_down_n_i,
  // speaker level detectors
  input  wire logic        spk_above_limit_i,
  input  wire logic        spk_below_target_i,
  input  wire logic        spk_zero_cross_i,
  // aux input
  output logic [3:0]       aux_gain_code_o,
  output logic [5:0]       aux_gain_db_o,
  // beep paths
  output logic             stereo_beep_power_o,
  output logic             stereo_beep_to_hp_o,
  output logic             stereo_beep_to_spk_o,
  output logic             mono_beep_power_o,
  output logic             mono_beep_to_hp_o,
  output logic             mono_beep_to_spk_o,
  // headphone
  output logic             hp_common_up_o,
  output logic             hp_amp_down_o,
  output logic             hp_out_low_o,
  // speaker and mono out 2
  output logic             spk_blocks_on_o,
  output logic             spk_pos_hiz_o,
  output logic             spk_neg_half_o,
  output logic             mono_out_on_o,
  output logic             mono_out_to_ref_o,
  output logic             mono_out_hiz_o,
  output logic [7:0]       spk_atten_o,
  // mono line output
  output logic             dac_to_mono_o,
  output logic             mic_to_mono_o,
  output logic             mono_line_on_o,
  output logic             mono_line_hiz_o,
  output logic             mono_gain_high_o
);
  // ****
  // pin synchronisers
  // ****
  logic [7:0] sync1_reg;
  logic [7:0] sync2_reg;
  logic       csn_prev_reg;
  logic       clk_prev_reg;

  // every pin passes two flops before any logic reads it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      // select and serial clock idle high, so their copies start high: no false edge
      sync1_reg <= 8'h07;
      sync2_reg <= 8'h07;
    end else begin
      sync1_reg <= {spk_zero_cross_i, spk_below_target_i, spk_above_limit_i,
                    addr_strap_pin_i, ctrl_data_in_i, ctrl_serial_clock_i,
                    power_down_n_i, chip_select_n_i};
      sync2_reg <= sync1_reg;
    end
  end

  wire csn_s   = sync2_reg[0];
  wire pdn_s   = sync2_reg[1];
  wire sclk_s  = sync2_reg[2];
  wire din_s   = sync2_reg[3];
  wire strap_s = sync2_reg[4];
  wire above_s = sync2_reg[5];
  wire below_s = sync2_reg[6];
  wire zc_s    = sync2_reg[7];

  // register file reset covers both the system reset and the pin
  wire ctl_rst = rst_i | ~pdn_s;

  // edge detect on the synchronised copies only
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      csn_prev_reg <= 1'b1;
      clk_prev_reg <= 1'b1;
    end else begin
      csn_prev_reg <= csn_s;
      clk_prev_reg <= sclk_s;
    end
  end

  wire csn_fall  = ~csn_s & csn_prev_reg;
  wire csn_rise  = csn_s & ~csn_prev_reg;
  wire sclk_rise = ~csn_s & sclk_s & ~clk_prev_reg;
  wire sclk_fall = ~csn_s & ~sclk_s & clk_prev_reg;

  // ****
  // serial frame receiver
  // ****
  logic [4:0]  bit_cnt_reg;
  logic [15:0] shift_reg;
  logic [7:0]  tx_reg;
  logic        oe_reg;
  logic [7:0]  regs_reg [0:14];

  wire       frame_open = bit_cnt_reg < `COPC_FRAME_BITS;
  wire       take_bit   = sclk_rise & frame_open;
  // first bit in ends at bit 15: chip address, direction, address, data
  wire       hdr_hi  = shift_reg[15];
  wire       hdr_lo  = shift_reg[14];
  wire       hdr_rw  = shift_reg[13];
  wire [4:0] hdr_adr = shift_reg[12:8];
  // during a read only eight bits have arrived, so the header sits low
  wire       rd_hi   = shift_reg[7];
  wire       rd_lo   = shift_reg[6];
  wire       rd_rw   = shift_reg[5];
  wire [4:0] rd_adr  = shift_reg[4:0];
  wire       wr_match = (hdr_hi == `COPC_CHIP_HI) & (hdr_lo == strap_s);
  wire       rd_match = (rd_hi == `COPC_CHIP_HI) & (rd_lo == strap_s);
  wire       commit = csn_rise & (bit_cnt_reg == `COPC_FRAME_BITS) & wr_match &
                      (hdr_rw != `COPC_RW_READ) & (hdr_adr < `COPC_NUM_REGS);
  wire       rd_start = sclk_fall & (bit_cnt_reg == `COPC_HDR_BITS) & rd_match &
                        (rd_rw == `COPC_RW_READ);
  wire [7:0] rd_val = (rd_adr < `COPC_NUM_REGS) ? regs_reg[rd_adr[3:0]] : 8'h00;
  wire       tx_shift = sclk_fall & oe_reg & (bit_cnt_reg > `COPC_HDR_BITS) & frame_open;

  // bit counter restarts at each select fall
  always_ff @(posedge clk_i) begin
    if (ctl_rst || csn_fall) begin
      bit_cnt_reg <= 5'h00;
      shift_reg <= 16'h0000;
    end else if (take_bit) begin
      bit_cnt_reg <= bit_cnt_reg + 5'h01;
      shift_reg <= {shift_reg[14:0], din_s};
    end
  end

  // read data leaves on falling serial clock edges
  always_ff @(posedge clk_i) begin
    if (ctl_rst || csn_rise) begin
      tx_reg <= 8'h00;
      oe_reg <= 1'b0;
    end else if (rd_start) begin
      tx_reg <= rd_val;
      oe_reg <= 1'b1;
    end else if (tx_shift) begin
      tx_reg <= {tx_reg[6:0], 1'b0};
    end
  end

  assign ctrl_data_out_o = tx_reg[7];
  assign ctrl_data_out_oe_o = oe_reg;

  // ****
  // control register file
  // ****
  // a write lands only when the whole frame is in and select rises
  always_ff @(posedge clk_i) begin
    if (ctl_rst) begin
      for (int i = 0; i < 15; i++) begin
        regs_reg[i] <= `COPC_RST_ZERO;
      end
      regs_reg[`COPC_A_ALC] <= `COPC_RST_ALC;
      regs_reg[`COPC_A_VOL] <= `COPC_RST_VOL;
    end else if (commit) begin
      regs_reg[hdr_adr[3:0]] <= shift_reg[7:0];
    end
  end

  wire [7:0] pm1  = regs_reg[`COPC_A_PM1];
  wire [7:0] pm2  = regs_reg[`COPC_A_PM2];
  wire [7:0] sel1 = regs_reg[`COPC_A_SEL1];
  wire [7:0] sel2 = regs_reg[`COPC_A_SEL2];
  wire [7:0] mod2 = regs_reg[`COPC_A_MOD2];
  wire [7:0] tmr  = regs_reg[`COPC_A_TMR];
  wire [7:0] alc  = regs_reg[`COPC_A_ALC];
  wire [7:0] vol  = regs_reg[`COPC_A_VOL];

  // ****
  // analog path controls
  // ****
  wire spk_pwr  = pm2[`COPC_B_SPK_POWER];
  wire hp_pwr   = pm2[`COPC_B_HP_LEFT_POWER] & pm2[`COPC_B_HP_RIGHT_POWER];
  wire hp_sd    = sel2[`COPC_B_HPLSD] & sel2[`COPC_B_HPRSD];
  wire save_off = mod2[`COPC_B_SPEAKER_SAVE_OFF];
  wire mo_en    = sel1[`COPC_B_MOUT];
  wire line_pwr = pm1[`COPC_B_MONO_LINE_POWER];

  // aux gain in dB is three per code step above the -21 dB of code zero
  assign aux_gain_code_o = vol[3:0];
  assign aux_gain_db_o = 6'(({2'b00, vol[3:0]} * `COPC_AUX_STEP_DB) - `COPC_AUX_MIN_DB);

  // beep routing; the host keeps mono-to-speaker clear when idle
  assign stereo_beep_power_o = pm1[`COPC_B_BPS];
  assign stereo_beep_to_hp_o = sel2[`COPC_B_STEREO_BEEP_TO_HP];
  assign stereo_beep_to_spk_o = sel1[`COPC_B_STEREO_BEEP_TO_SPK];
  assign mono_beep_power_o = pm1[`COPC_B_BPM];
  assign mono_beep_to_hp_o = sel2[`COPC_B_MONO_BEEP_TO_HP];
  assign mono_beep_to_spk_o = sel1[`COPC_B_MONO_BEEP_TO_SPK];

  // headphone common rises only with both power bits set
  assign hp_common_up_o = hp_pwr;
  assign hp_amp_down_o = hp_sd;
  assign hp_out_low_o = ~hp_pwr | hp_sd;

  // speaker group; power-save parks the negative pin at half supply
  assign spk_blocks_on_o = spk_pwr;
  assign spk_pos_hiz_o = ~spk_pwr | ~save_off;
  assign spk_neg_half_o = spk_pwr & ~save_off;
  assign mono_out_hiz_o = ~spk_pwr;
  assign mono_out_on_o = spk_pwr & mo_en;
  assign mono_out_to_ref_o = spk_pwr & ~mo_en;

  // mono line output
  assign dac_to_mono_o = sel1[`COPC_B_DAC_TO_MONO];
  assign mic_to_mono_o = sel1[`COPC_B_MIC_TO_MONO];
  assign mono_line_on_o = line_pwr;
  assign mono_line_hiz_o = ~line_pwr;
  assign mono_gain_high_o = sel1[`COPC_B_MONO_GAIN_SEL];

  // ****
  // sample rate tick and level controller
  // ****
  logic [15:0] fs_div_reg;
  logic [15:0] fs_cnt_reg;
  logic        init_busy;
  logic        limiting;

  // a divider of zero degrades to a tick every clock
  wire fs_tick = fs_cnt_reg >= fs_div_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i || fs_tick) begin
      fs_cnt_reg <= 16'h0000;
    end else begin
      fs_cnt_reg <= fs_cnt_reg + 16'h0001;
    end
  end

  copc_spk_level u_level (
    .clk_i          (clk_i),
    .rst_i          (ctl_rst),
    .fs_tick_i      (fs_tick),
    .spk_power_i    (spk_pwr),
    .level_en_i     (alc[`COPC_B_SPEAKER_LEVEL_CTL_EN]),
    .period_sel_i   (tmr[`COPC_B_RECOVERY_PERIOD_SEL]),
    .above_limit_i  (above_s),
    .below_target_i (below_s),
    .zero_cross_i   (zc_s),
    .atten_o        (spk_atten_o),
    .init_busy_o    (init_busy),
    .limiting_o     (limiting)
  );

  // ****
  // apb slave
  // ****
  logic [31:0] prdata_reg;

  wire apb_setup = psel_i & ~penable_i;
  wire apb_acc   = psel_i & penable_i;
  wire hit_div   = paddr_i == `COPC_APB_FSDIV;
  wire hit_sts   = paddr_i == `COPC_APB_STATUS;
  wire [31:0] sts_word = {22'h000000, limiting, init_busy, spk_atten_o};
  wire [31:0] rd_mux = hit_div ? {16'h0000, fs_div_reg} : (hit_sts ? sts_word : 32'h00000000);

  // read data is captured in setup so it stands through access
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prdata_reg <= 32'h00000000;
      fs_div_reg <= `COPC_RST_FSDIV;
    end else begin
      if (apb_setup && !pwrite_i) begin
        prdata_reg <= rd_mux;
      end
      if (apb_acc && pwrite_i && hit_div) begin
        fs_div_reg <= pwdata_i[15:0];
      end
    end
  end

  assign prdata_o = prdata_reg;
  assign pready_o = 1'b1;
  assign pslverr_o = apb_acc & ~hit_div & ~(hit_sts & ~pwrite_i);

  // ****
  // checks
  // ****
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence wr_frame_s;
    csn_rise && bit_cnt_reg == `COPC_FRAME_BITS && hdr_rw != `COPC_RW_READ;
  endsequence
  aux_db_a: assert property ($signed(aux_gain_db_o) ==
    $signed(7'(vol[3:0]) * 7'sd3 - 7'sd21)) else $error("aux gain wrong");
  commit_a: assert property (commit && !ctl_rst |=>
    regs_reg[$past(hdr_adr[3:0])] == $past(shift_reg[7:0]))
    else $error("write not committed");
  release_a: assert property (csn_rise |=> !ctrl_data_out_oe_o)
    else $error("data out not released");
  mismatch_a: assert property (wr_frame_s and !wr_match |=> $stable(vol) && $stable(pm2))
    else $error("foreign frame accepted");
  pdn_hold_a: assert property (!pdn_s |=> vol == `COPC_RST_VOL && pm2 == `COPC_RST_ZERO)
    else $error("registers not held");
  spk_hiz_a: assert property (!spk_pwr |-> spk_pos_hiz_o && mono_out_hiz_o && !spk_neg_half_o)
    else $error("speaker pins not hi-z");
  hp_low_a: assert property (hp_sd |-> hp_out_low_o && hp_amp_down_o)
    else $error("headphone not low");
  count_a: assert property (csn_fall |=> bit_cnt_reg == 5'h00)
    else $error("frame count not restarted");
endmodule : copc_top

// [testbench/copc_host_model.sv]
`timescale 1ns/1ps
// ****
// host side of the serial control port
// ****
module copc_host_model (
  // serial pins
  output logic      chip_select_n_o,
  output logic      ctrl_serial_clock_o,
  output logic      ctrl_data_in_o,
  input  wire logic ctrl_data_out_i
);
  // serial clock idles high and stands still between frames
  initial begin
    chip_select_n_o = 1'b1;
    ctrl_serial_clock_o = 1'b1;
    ctrl_data_in_o = 1'b0;
  end

  // one 16-bit frame; a read samples the device on each of the last eight rises
  task automatic frame(input logic rd, input logic [1:0] chip, input logic [4:0] addr,
                       input logic [7:0] wd, output logic [7:0] rdata);
    logic [15:0] bits;
    bits = {chip, rd, addr, wd};
    rdata = 8'h00;
    // pins move by non-blocking assignment: an edge on a system clock edge is never raced
    chip_select_n_o <= 1'b0;
    #30;
    for (int i = 15; i >= 0; i--) begin
      ctrl_serial_clock_o <= 1'b0;
      ctrl_data_in_o <= (rd && i < 8) ? i[0] : bits[i]; // idle data toggles, not a copy
      #24;
      ctrl_serial_clock_o <= 1'b1;
      if (i < 8) rdata[i] = ctrl_data_out_i;
      #24;
    end
    #30;
    chip_select_n_o <= 1'b1;
    // leave room for the commit before the next frame
    #100;
  endtask : frame
endmodule : copc_host_model

// [testbench/test_codec_output_path_ctrl.sv]
`timescale 1ns/1ps
// ****
// top-level bench
// ****
module test_codec_output_path_ctrl;
  logic clk_i = 1'b0, rst_i = 1'b1, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
  logic addr_strap_pin_i = 1'b1, power_down_n_i = 1'b1, spk_above_limit_i = 1'b0;
  logic spk_below_target_i = 1'b0, spk_zero_cross_i = 1'b0, zc_run = 1'b0, err;
  logic chip_select_n_i, ctrl_serial_clock_i, ctrl_data_in_i, sdo_last = 1'b0;
  logic pready_o, pslverr_o, ctrl_data_out_o, ctrl_data_out_oe_o;
  logic [3:0] aux_gain_code_o;
  logic [5:0] aux_gain_db_o;
  logic [7:0] spk_atten_o, sd, att;
  logic stereo_beep_power_o, stereo_beep_to_hp_o, stereo_beep_to_spk_o, mono_beep_power_o;
  logic mono_beep_to_hp_o, mono_beep_to_spk_o, hp_common_up_o, hp_amp_down_o, hp_out_low_o;
  logic spk_blocks_on_o, spk_pos_hiz_o, spk_neg_half_o, mono_out_on_o, mono_out_to_ref_o;
  logic mono_out_hiz_o, dac_to_mono_o, mic_to_mono_o, mono_line_on_o, mono_line_hiz_o;
  logic mono_gain_high_o;
  wire sdo_w = ctrl_data_out_oe_o ? ctrl_data_out_o : ~sdo_last;
  int miscompares = 0, n_compared = 0;

  always #2.5 clk_i = ~clk_i;
  // released data line shows the inverse of its last driven level
  always @(posedge clk_i) if (ctrl_data_out_oe_o) sdo_last <= ctrl_data_out_o;
  // zero-crossing detector pulses steadily once recovery is under test
  always @(posedge clk_i) spk_zero_cross_i <= zc_run & ~spk_zero_cross_i;

  copc_top copc_top_i (.clk_i, .rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
    .prdata_o, .pready_o, .pslverr_o, .chip_select_n_i, .ctrl_serial_clock_i, .ctrl_data_in_i,
    .ctrl_data_out_o, .ctrl_data_out_oe_o, .addr_strap_pin_i, .power_down_n_i,
    .spk_above_limit_i, .spk_below_target_i, .spk_zero_cross_i, .aux_gain_code_o,
    .aux_gain_db_o, .stereo_beep_power_o, .stereo_beep_to_hp_o, .stereo_beep_to_spk_o,
    .mono_beep_power_o, .mono_beep_to_hp_o, .mono_beep_to_spk_o, .hp_common_up_o,
    .hp_amp_down_o, .hp_out_low_o, .spk_blocks_on_o, .spk_pos_hiz_o, .spk_neg_half_o,
    .mono_out_on_o, .mono_out_to_ref_o, .mono_out_hiz_o, .spk_atten_o, .dac_to_mono_o,
    .mic_to_mono_o, .mono_line_on_o, .mono_line_hiz_o, .mono_gain_high_o);
  copc_host_model copc_host_model_i (.chip_select_n_o(chip_select_n_i),
    .ctrl_serial_clock_o(ctrl_serial_clock_i), .ctrl_data_in_o(ctrl_data_in_i),
    .ctrl_data_out_i(sdo_w));

  // one bit wider than a bus word so the error flag is compared alongside read data
  task automatic check(input string what, input logic [32:0] seen, input logic [32:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic complete_run();
    $display("compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : complete_run

  // apb transfer; held until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk_i);
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= wd;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do @(posedge clk_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb

  task automatic ser(input logic rdn, input logic [1:0] chip, input logic [4:0] a,
                     input logic [7:0] d);
    copc_host_model_i.frame(rdn, chip, a, d, sd);
  endtask : ser

  // long level-control waits bound the watchdog
  initial begin
    repeat (40000) @(posedge clk_i);
    miscompares++;
    complete_run();
  end

  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    check("aux reset", {aux_gain_code_o, aux_gain_db_o}, {4'h7, 6'h00});
    apb(1'b0, 8'h00, 32'h0);
    check("fsdiv reset", {err, rd}, {1'b0, 32'h000011B7});
    apb(1'b1, 8'h00, 32'h00000003); // short sample period
    apb(1'b0, 8'h00, 32'h0);
    check("fsdiv rw", {err, rd}, {1'b0, 32'h00000003});
    apb(1'b1, 8'h04, 32'hFFFFFFFF);
    check("status wr", err, 1'b1);
    apb(1'b0, 8'h08, 32'h0);
    check("unmapped", {err, rd}, {1'b1, 32'h0});
    ser(1'b0, 2'b11, 5'h08, 8'h40);
    ser(1'b0, 2'b11, 5'h0E, 8'h0F);
    check("aux max", aux_gain_db_o, 6'h18);
    ser(1'b0, 2'b11, 5'h0E, 8'h00);
    check("aux min", aux_gain_db_o, 6'h2B);
    ser(1'b0, 2'b10, 5'h0E, 8'h05);
    check("wrong chip", aux_gain_code_o, 4'h0);
    ser(1'b1, 2'b11, 5'h08, 8'h00);
    check("serial read", sd, 8'h40);
    check("out released", ctrl_data_out_oe_o, 1'b0);
    ser(1'b0, 2'b11, 5'h00, 8'h68);
    check("pm1", {stereo_beep_power_o, mono_beep_power_o, mono_line_on_o, mono_line_hiz_o},
          4'b1110);
    ser(1'b0, 2'b11, 5'h02, 8'hBD);
    check("sel1", {mono_gain_high_o, dac_to_mono_o, mic_to_mono_o, stereo_beep_to_spk_o,
          mono_beep_to_spk_o, mono_out_on_o}, 6'b111110);
    ser(1'b0, 2'b11, 5'h03, 8'h0C);
    check("sel2", {stereo_beep_to_hp_o, mono_beep_to_hp_o, hp_amp_down_o}, 3'b110);
    check("spk off", {spk_blocks_on_o, spk_pos_hiz_o, mono_out_hiz_o}, 3'b011);
    ser(1'b0, 2'b11, 5'h01, 8'h0E);
    apb(1'b0, 8'h04, 32'h0);
    check("init busy", rd[8], 1'b1);
    check("pm2", {hp_common_up_o, hp_out_low_o, spk_blocks_on_o, spk_pos_hiz_o,
          spk_neg_half_o, mono_out_hiz_o}, 6'b101110);
    ser(1'b0, 2'b11, 5'h05, 8'h01);
    check("save off", {spk_pos_hiz_o, spk_neg_half_o}, 2'b00);
    ser(1'b0, 2'b11, 5'h02, 8'hB8);
    check("mono out off", {mono_beep_to_spk_o, mono_out_on_o, mono_out_to_ref_o},
          3'b001);
    ser(1'b0, 2'b11, 5'h01, 8'h08);
    check("hp fall", {hp_common_up_o, hp_out_low_o}, 2'b01);
    ser(1'b0, 2'b11, 5'h03, 8'h0F);
    check("hp down", {hp_amp_down_o, hp_out_low_o}, 2'b11);
    repeat (2300) @(posedge clk_i);
    apb(1'b0, 8'h04, 32'h0);
    check("init done", rd[9:0], 10'h000);
    spk_above_limit_i <= 1'b1;
    repeat (400) @(posedge clk_i);
    apb(1'b0, 8'h04, 32'h0);
    check("limiting", {rd[9], rd[7:0] >= 8'h30 && rd[7:0] <= 8'h33}, 2'b11);
    spk_above_limit_i <= 1'b0;
    repeat (20) @(posedge clk_i);
    att = spk_atten_o;
    repeat (1500) @(posedge clk_i);
    check("hold", spk_atten_o, att);
    spk_below_target_i <= 1'b1;
    zc_run <= 1'b1;
    repeat (3000) @(posedge clk_i);
    check("recover", spk_atten_o, att - 8'h02);
    // with no zero crossings the next step waits for the period plus the timeout
    zc_run <= 1'b0;
    repeat (9800) @(posedge clk_i);
    check("zc timeout", spk_atten_o, att - 8'h04);
    power_down_n_i <= 1'b0;
    repeat (10) @(posedge clk_i);
    check("power down", {aux_gain_code_o, stereo_beep_power_o}, 5'b01110);
    power_down_n_i <= 1'b1;
    complete_run();
  end
endmodule : test_codec_output_path_ctrl
